// ---- verilog/drive_sup_defines.svh ----
/*
  Register offsets, field positions, reset values and timing figures of the
  drive supervisor. Assumes a 200 MHz control clock and APB byte addresses.
*/
`ifndef DRIVE_SUP_DEFINES_SVH
`define DRIVE_SUP_DEFINES_SVH

// Register byte offsets
`define OFS_RETRY_CFG   8'h00
`define OFS_CATCH_CFG   8'h04
`define OFS_SLEEP_CFG   8'h08
`define OFS_SLEEP_THR   8'h0C
`define OFS_STATUS      8'h10
`define OFS_IRQ_STAT    8'h14
`define OFS_IRQ_MASK    8'h18
`define OFS_COMMAND     8'h1C

// Field positions
`define F_DELAY_LSB     16
`define F_BOOST_LSB     16
`define F_SLEEP_OFF     15
`define F_RESUME_LSB    16

// Encodings and limits
`define MODE_MANUAL     4'h0
`define MODE_X10        4'h6
`define MODE_X15        4'h7
`define MODE_X20        4'h8
`define MODE_INFINITE   4'h9
`define CATCH_OFF       2'h0
`define CATCH_ON        2'h1
`define DELAY_MAX_S     11'h708
`define SLEEP_MAX_S     9'h12C
`define BOOST_MIN_PCT   8'h01
`define BOOST_MAX_PCT   8'hC8

// Reset values
`define RST_DELAY_S     11'h00A
`define RST_BOOST_PCT   8'h64
`define RST_SLEEP_THR   16'h0000
`define RST_RESUME_THR  16'h01F4

// Timing
`define NS_PER_SEC      1000000000
`define CLK_PERIOD_NS   5
`define BOOST_TIMEOUT_S 11'h01E

`endif

// ---- verilog/drive_sup_pkg.sv ----
/*
  Types of the drive supervisor: state enums and the status and command
  bundles exchanged with the motor control core.
*/
package drive_sup_pkg;

  typedef enum logic [1:0] {RT_RUN, RT_WAIT, RT_LOCKED} retry_state_t;
  typedef enum logic [2:0] {SL_AWAKE, SL_BOOST, SL_RAMP, SL_SLEEP} sleep_state_t;
  typedef enum logic {CT_IDLE, CT_BRAKE} catch_state_t;

  // Same-clock status from the motor core; frequencies in 0.1 Hz units
  typedef struct packed {
    logic        closed_loop;
    logic        local_ref;
    logic        jog_sel;
    logic        dc_brake_en;
    logic        brake_done;
    logic        boost_reached;
    logic        motor_stopped;
    logic [15:0] out_freq;
    logic [15:0] theo_freq;
    logic [15:0] motor_speed;
    logic [15:0] f_max;
  } drive_in_t;

  typedef struct packed {
    logic       fault_reset;
    logic       restart;
    logic       catch_req;
    logic       dc_brake;
    logic       boost_on;
    logic       ramp_down;
    logic       sleeping;
    logic [7:0] setpoint_pct;
  } drive_out_t;

endpackage

// ---- verilog/drive_sleep_autoreset_ctrl.sv ----
/*
  Supervisory control of a motor drive: trip recovery, spinning-motor catch
  and sleep mode, with an APB register slave and one level interrupt.
  Assumes pin inputs are asynchronous and the drive_in bundle is on pclk.
*/
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "drive_sup_defines.svh"

// Functional notes
// - Recovery code: 0 manual, 1-5, 10, 15, 20, infinite
// - Manual mode clears trip only by key/input; the code also clears it on a write of bit 0 to the COMMAND register
// - Auto modes retry, never beyond selected count; the code loads the count only on a manual reset (0 after presetn)
// - Programmable 0-1800 s delay before each attempt
// - Catch code: 0 off, 1 on, brake code
// - Catch on every start, motor below f_max
// - Brake mode: DC brake first, then restart; on a retry attempt or a wake the code also sends restart before the brake
// - No sleep under local reference or jog
// - Sleep timer runs below threshold, clears above
// - Timer expiry: ramp down, then sleep
// - Sleeping: wake when theoretical exceeds resume threshold
// - Sleep timer 0-300 s or off, default off
// - Sleep threshold capped by resume threshold
// - Resume threshold capped by f_max, default 50 Hz
// - Boost 1-200 %, closed loop, before sleep
// - Boost abandoned after fixed 30 s
module drive_sleep_autoreset_ctrl
  import drive_sup_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `NS_PER_SEC / `CLK_PERIOD_NS
)(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Asynchronous pins
  input  wire logic        trip_pin,
  input  wire logic        reset_key_pin,
  input  wire logic        reset_din_pin,
  input  wire logic        start_pin,
  // Motor core
  input  wire drive_in_t   drive_in,
  output drive_out_t       drive_out,
  // Interrupt
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: a level counts once the 2nd and 3rd stages agree

  localparam int NPIN = 4;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_f;
  logic            trip_f;
  logic            key_f;
  logic            din_f;
  logic            start_f;
  logic            start_prev_q;

  assign pin_raw = {start_pin, reset_din_pin, reset_key_pin, trip_pin};
  assign trip_f  = pin_f[0];
  assign key_f   = pin_f[1];
  assign din_f   = pin_f[2];
  assign start_f = pin_f[3];

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++)
    begin : g_sync
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic f_q;
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
          f_q  <= 1'b0;
        end
        else
        begin
          s1_q <= pin_raw[gi];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q)
            f_q <= s3_q;
        end
      end
      assign pin_f[gi] = f_q;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // One-second tick; free running, so the sleep wait may end up to one tick early and the retry delay and boost time-out up to one tick late

  logic [31:0] pre_q;
  logic        sec_tick;

  assign sec_tick = (pre_q == 32'(TICK_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pre_q <= 32'h0000_0000;
    else if (sec_tick)
      pre_q <= 32'h0000_0000;
    else
      pre_q <= pre_q + 32'h0000_0001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB register file

  logic [3:0]  retry_mode_q;
  logic [10:0] retry_delay_q;
  logic [1:0]  catch_mode_q;
  logic        sleep_off_q;
  logic [8:0]  sleep_time_q;
  logic [7:0]  boost_pct_q;
  logic [15:0] sleep_thr_q;
  logic [15:0] resume_thr_q;
  logic [4:0]  irq_mask_q;
  logic [4:0]  irq_stat_q;
  logic [4:0]  irq_set;
  logic        wr;
  logic        rd_setup;
  logic        mapped;
  logic        sw_reset;
  logic [31:0] rd_d;
  logic [31:0] status_word;

  assign pready  = 1'b1;
  assign wr      = psel && penable && pwrite;
  assign rd_setup = psel && !penable;
  assign pslverr = psel && penable && !mapped;
  assign sw_reset = wr && (paddr == `OFS_COMMAND) && pwdata[0];
  assign irq     = |(irq_stat_q & irq_mask_q);

  always_comb
  begin
    mapped = 1'b1;
    rd_d   = 32'h0000_0000;
    if (paddr == `OFS_RETRY_CFG)
      rd_d = {5'h00, retry_delay_q, 12'h000, retry_mode_q};
    else if (paddr == `OFS_CATCH_CFG)
      rd_d = {30'h0000_0000, catch_mode_q};
    else if (paddr == `OFS_SLEEP_CFG)
      rd_d = {8'h00, boost_pct_q, sleep_off_q, 6'h00, sleep_time_q};
    else if (paddr == `OFS_SLEEP_THR)
      rd_d = {resume_thr_q, sleep_thr_q};
    else if (paddr == `OFS_STATUS)
      rd_d = status_word;
    else if (paddr == `OFS_IRQ_STAT)
      rd_d = {27'h000_0000, irq_stat_q};
    else if (paddr == `OFS_IRQ_MASK)
      rd_d = {27'h000_0000, irq_mask_q};
    else if (paddr == `OFS_COMMAND)
      rd_d = 32'h0000_0000;
    else
      mapped = 1'b0;
  end

  // Read data is captured in the setup phase so it stands in the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (rd_setup)
      prdata <= rd_d;
  end

  // Out-of-range writes are clamped to the nearest legal setting, except a retry mode above 9, which becomes manual
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      retry_mode_q  <= `MODE_MANUAL;
      retry_delay_q <= `RST_DELAY_S;
      catch_mode_q  <= `CATCH_OFF;
      sleep_off_q   <= 1'b1;
      sleep_time_q  <= 9'h000;
      boost_pct_q   <= `RST_BOOST_PCT;
      sleep_thr_q   <= `RST_SLEEP_THR;
      resume_thr_q  <= `RST_RESUME_THR;
      irq_mask_q    <= 5'h00;
    end
    else if (wr)
    begin
      if (paddr == `OFS_RETRY_CFG)
      begin
        retry_mode_q  <= (pwdata[3:0] > `MODE_INFINITE) ? `MODE_MANUAL
                                                          : pwdata[3:0];
        retry_delay_q <= (pwdata[26:16] > `DELAY_MAX_S) ? `DELAY_MAX_S
                                                          : pwdata[26:16];
      end
      else if (paddr == `OFS_CATCH_CFG)
        catch_mode_q <= pwdata[1:0];
      else if (paddr == `OFS_SLEEP_CFG)
      begin
        sleep_off_q  <= pwdata[`F_SLEEP_OFF];
        sleep_time_q <= (pwdata[8:0] > `SLEEP_MAX_S) ? `SLEEP_MAX_S : pwdata[8:0];
        if (pwdata[23:16] < `BOOST_MIN_PCT)
          boost_pct_q <= `BOOST_MIN_PCT;
        else if (pwdata[23:16] > `BOOST_MAX_PCT)
          boost_pct_q <= `BOOST_MAX_PCT;
        else
          boost_pct_q <= pwdata[23:16];
      end
      else if (paddr == `OFS_SLEEP_THR)
      begin
        sleep_thr_q  <= pwdata[15:0];
        resume_thr_q <= pwdata[31:16];
      end
      else if (paddr == `OFS_IRQ_MASK)
        irq_mask_q <= pwdata[4:0];
    end
  end

  // Write-one-to-clear; a new event in the same cycle wins over the clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_stat_q <= 5'h00;
    else if (wr && paddr == `OFS_IRQ_STAT)
      irq_stat_q <= (irq_stat_q & ~pwdata[4:0]) | irq_set;
    else
      irq_stat_q <= irq_stat_q | irq_set;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trip recovery

  retry_state_t rt_q;
  logic [4:0]   left_q;
  logic [10:0]  rt_cnt_q;
  logic         man_reset;
  logic         attempt;
  logic         unlimited;
  logic [4:0]   quota;

  function automatic logic [4:0] quota_of(input logic [3:0] m);
    logic [4:0] q;
    q = 5'h00;
    if (m == `MODE_X10)
      q = 5'h0A;
    else if (m == `MODE_X15)
      q = 5'h0F;
    else if (m == `MODE_X20)
      q = 5'h14;
    else if (m < `MODE_X10)
      q = {1'b0, m};
    return q;
  endfunction

  assign quota     = quota_of(retry_mode_q);
  assign unlimited = (retry_mode_q == `MODE_INFINITE);
  assign man_reset = key_f || din_f || sw_reset;
  assign attempt   = (rt_q == RT_WAIT) &&
                     ((retry_delay_q == 11'h000) || (rt_cnt_q > retry_delay_q));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rt_q     <= RT_RUN;
      left_q   <= 5'h00;
      rt_cnt_q <= 11'h000;
    end
    else
    begin
      case (rt_q)
        RT_RUN:
          if (trip_f)
          begin
            rt_cnt_q <= 11'h000;
            if (retry_mode_q == `MODE_MANUAL)
              rt_q <= RT_LOCKED;
            else if (!unlimited && left_q == 5'h00)
              rt_q <= RT_LOCKED;
            else
              rt_q <= RT_WAIT;
          end
        RT_WAIT:
          if (man_reset)
          begin
            rt_q   <= RT_RUN;
            left_q <= quota;
          end
          else if (attempt)
          begin
            rt_q <= RT_RUN;
            if (!unlimited)
              left_q <= left_q - 5'h01;
          end
          else if (sec_tick && rt_cnt_q != 11'h7FF)
            rt_cnt_q <= rt_cnt_q + 11'h001;
        default:
          if (man_reset)
          begin
            rt_q   <= RT_RUN;
            left_q <= quota;
          end
      endcase
      if (rt_q == RT_RUN && !trip_f && man_reset)
        left_q <= quota;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sleep mode

  sleep_state_t sl_q;
  logic [8:0]   sl_cnt_q;
  logic [10:0]  bst_cnt_q;
  logic [15:0]  resume_eff;
  logic [15:0]  sleep_eff;
  logic         sleep_allowed;
  logic         below;
  logic         expired;
  logic         wake;

  assign resume_eff = (resume_thr_q > drive_in.f_max) ? drive_in.f_max
                                                       : resume_thr_q;
  assign sleep_eff  = (sleep_thr_q > resume_eff) ? resume_eff : sleep_thr_q;
  assign sleep_allowed = !sleep_off_q && !drive_in.local_ref &&
                         !drive_in.jog_sel && (rt_q == RT_RUN);
  assign below   = drive_in.out_freq < sleep_eff;
  assign expired = below && (sl_cnt_q >= sleep_time_q);
  assign wake    = (sl_q == SL_SLEEP) &&
                   ((drive_in.theo_freq > resume_eff) || !sleep_allowed);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sl_q      <= SL_AWAKE;
      sl_cnt_q  <= 9'h000;
      bst_cnt_q <= 11'h000;
    end
    else
    begin
      case (sl_q)
        SL_AWAKE:
          if (!sleep_allowed || !below)
            sl_cnt_q <= 9'h000;
          else if (expired)
          begin
            sl_cnt_q  <= 9'h000;
            bst_cnt_q <= 11'h000;
            if (drive_in.closed_loop && boost_pct_q != `RST_BOOST_PCT)
              sl_q <= SL_BOOST;
            else
              sl_q <= SL_RAMP;
          end
          else if (sec_tick)
            sl_cnt_q <= sl_cnt_q + 9'h001;
        SL_BOOST:
          if (!sleep_allowed)
            sl_q <= SL_AWAKE;
          else if (drive_in.boost_reached || bst_cnt_q > `BOOST_TIMEOUT_S)
            sl_q <= SL_RAMP;
          else if (sec_tick)
            bst_cnt_q <= bst_cnt_q + 11'h001;
        SL_RAMP:
          if (!sleep_allowed)
            sl_q <= SL_AWAKE;
          else if (drive_in.motor_stopped)
            sl_q <= SL_SLEEP;
        default:
          if (wake)
            sl_q <= SL_AWAKE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Spinning-motor catch; brake mode accepts both codes 2 and 3

  catch_state_t ct_q;
  logic         start_ev;
  logic         catch_ok;
  logic         brake_mode;

  assign start_ev   = (start_f && !start_prev_q) || attempt || wake;
  assign catch_ok   = drive_in.motor_speed < drive_in.f_max;
  assign brake_mode = catch_mode_q[1] && drive_in.dc_brake_en;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ct_q         <= CT_IDLE;
      start_prev_q <= 1'b0;
    end
    else
    begin
      start_prev_q <= start_f;
      case (ct_q)
        CT_IDLE:
          if (start_ev && brake_mode)
            ct_q <= CT_BRAKE;
        default:
          if (drive_in.brake_done || trip_f)
            ct_q <= CT_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Commands to the motor core and event flags

  logic brake_end;

  assign brake_end = (ct_q == CT_BRAKE) && drive_in.brake_done && !trip_f;
  assign irq_set = {wake,
                    (sl_q == SL_RAMP) && sleep_allowed && drive_in.motor_stopped,
                    (rt_q == RT_RUN) && trip_f && !unlimited &&
                      retry_mode_q != `MODE_MANUAL && left_q == 5'h00,
                    attempt && !man_reset,
                    (rt_q == RT_RUN) && trip_f};

  assign status_word = {17'h0_0000, left_q, catch_mode_q[1] ? 1'b1 : 1'b0,
                        ct_q == CT_BRAKE, sl_q, 1'b0, rt_q, irq, trip_f};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      drive_out <= '0;
    else
    begin
      drive_out.fault_reset <= (rt_q != RT_RUN) && (man_reset || attempt);
      drive_out.restart     <= (attempt && !man_reset) || wake || brake_end;
      drive_out.catch_req   <= (start_ev && catch_mode_q == `CATCH_ON && catch_ok) ||
                               (brake_end && catch_ok);
      drive_out.dc_brake    <= (ct_q == CT_BRAKE);
      drive_out.boost_on    <= (sl_q == SL_BOOST);
      drive_out.ramp_down   <= (sl_q == SL_RAMP) || (sl_q == SL_SLEEP);
      drive_out.sleeping    <= (sl_q == SL_SLEEP);
      drive_out.setpoint_pct <= (sl_q == SL_BOOST) ? boost_pct_q : `RST_BOOST_PCT;
    end
  end

endmodule

// ---- bench/drive_core_model.sv ----
/*
  Stand-in for the motor control core beside the supervisor: it finishes
  braking, ramping and boosting after a short delay; on request it ramps slowly, never completes a boost and cannot brake.
  Assumes the supervisor's drive_out bundle on pclk.
*/
`timescale 1ns/100ps
module drive_core_model
  import drive_sup_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Bench controls: {closed_loop, local_ref, jog_sel}
  input  wire logic [2:0]  loop_sel,
  input  wire logic [15:0] fout,
  input  wire logic [15:0] ftheo,
  input  wire logic        slow,
  // Supervisor side
  input  wire drive_out_t  drive_out,
  output drive_in_t        drive_in
);
  logic [7:0] wait_q;
  logic [7:0] lim;

  ////////////////////////////////////////////////////////////////////////////
  // One delay count for whatever request is pending
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      wait_q <= 8'h00;
    else if (drive_out.dc_brake || drive_out.ramp_down || drive_out.boost_on)
      wait_q <= wait_q + 8'h01;
    else
      wait_q <= 8'h00;

  assign lim = slow ? 8'h0C : 8'h04;

  // A slow core never reaches the boosted pressure and has DC braking disabled
  always_comb
  begin
    drive_in = '0;
    {drive_in.closed_loop, drive_in.local_ref, drive_in.jog_sel} = loop_sel;
    drive_in.dc_brake_en   = !slow;
    drive_in.brake_done    = drive_out.dc_brake && wait_q > lim;
    drive_in.motor_stopped = drive_out.ramp_down && wait_q > lim;
    drive_in.boost_reached = drive_out.boost_on && !slow && wait_q > lim;
    drive_in.out_freq      = fout;
    drive_in.theo_freq     = ftheo;
    drive_in.motor_speed   = fout;
    drive_in.f_max         = 16'h0258;
  end
endmodule

// ---- bench/drive_sleep_autoreset_ctrl_assertions.sv ----
/*
  Concurrent checks on the supervisor's ports.
  Assumes one pclk domain; TICK_CYCLES is handed on by the bind.
*/
`timescale 1ns/100ps
module drive_sleep_autoreset_ctrl_assertions
  import drive_sup_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = 10
)(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  // Motor core
  input wire drive_in_t   drive_in,
  input wire drive_out_t  drive_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  int unsigned boost_q;

  // Length of the current boost phase
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      boost_q <= 0;
    else
      boost_q <= drive_out.boost_on ? boost_q + 1 : 0;

  sequence brake_over;
    $fell(drive_out.dc_brake);
  endsequence
  // Restart is launched one edge before the level that it ends falls
  sequence restart_prior;
    $past(drive_out.restart);
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  a_ready_always: assert property (pready)
    else $error("pready low");
  a_unmapped_err: assert property (psel && penable && paddr[1:0] == 2'h0
    |-> pslverr == (paddr > 8'h1C)) else $error("pslverr wrong for address");
  a_fault_pulse: assert property (drive_out.fault_reset |=> !drive_out.fault_reset)
    else $error("fault_reset longer than one cycle");
  a_restart_pulse: assert property (drive_out.restart |=> !drive_out.restart)
    else $error("restart longer than one cycle");
  a_sleep_ramp: assert property ($rose(drive_out.sleeping) |-> $past(drive_out.ramp_down))
    else $error("sleep entered without ramp down");
  a_brake_enabled: assert property ($rose(drive_out.dc_brake) |-> drive_in.dc_brake_en)
    else $error("brake without enable");
  a_brake_restart: assert property (brake_over |-> restart_prior)
    else $error("no restart after brake");
  a_boost_bound: assert property (boost_q <= 32 * TICK_CYCLES)
    else $error("boost outlasts time-out");
  a_boost_closed: assert property ($rose(drive_out.boost_on) |-> $past(drive_in.closed_loop))
    else $error("boost in open loop");
  a_setpoint_idle: assert property ($past(presetn, 2) && !drive_out.boost_on
    |-> drive_out.setpoint_pct == 8'h64) else $error("setpoint not 100");
  a_wake_restart: assert property ($fell(drive_out.sleeping) |-> restart_prior)
    else $error("wake without restart");
endmodule

bind drive_sleep_autoreset_ctrl drive_sleep_autoreset_ctrl_assertions
  #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .drive_in(drive_in), .drive_out(drive_out));

// ---- bench/drive_sleep_autoreset_ctrl_tb.sv ----
/*
  Self-checking bench for the drive supervisor: APB tasks, pin stimulus
  and a core model. Assumes a one-second tick shortened to TICK cycles.
*/
`timescale 1ns/100ps
`include "drive_sup_defines.svh"
module drive_sleep_autoreset_ctrl_tb;
  import drive_sup_pkg::*;
  localparam int unsigned TICK = 10;
  localparam int TRIES [9] = '{1, 2, 3, 4, 5, 10, 15, 20, 25};

  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr, irq, slv_q;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        trip, rkey, rdin, start, slow;
  logic [2:0]  loop_sel;
  logic [15:0] fout, ftheo;
  drive_in_t   drive_in;
  drive_out_t  drive_out;
  int          err_total = 0;
  int          cmp_count = 0;
  int          n_fault = 0, n_restart = 0, n_catch = 0, n_brake = 0, n_boost = 0, n_bad = 0;

  drive_sleep_autoreset_ctrl #(.TICK_CYCLES(TICK)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trip_pin(trip), .reset_key_pin(rkey), .reset_din_pin(rdin), .start_pin(start),
    .drive_in(drive_in), .drive_out(drive_out), .irq(irq));
  drive_core_model core_u (.pclk(pclk), .presetn(presetn), .loop_sel(loop_sel),
    .fout(fout), .ftheo(ftheo), .slow(slow), .drive_out(drive_out), .drive_in(drive_in));

  always #2.5 pclk = ~pclk;

  // Pulse and level counters
  always @(posedge pclk)
  begin
    n_fault   <= n_fault + drive_out.fault_reset;
    n_restart <= n_restart + drive_out.restart;
    n_catch   <= n_catch + drive_out.catch_req;
    n_brake   <= n_brake + drive_out.dc_brake;
    n_boost   <= n_boost + drive_out.boost_on;
    n_bad     <= n_bad + (drive_out.boost_on && drive_out.setpoint_pct !== 8'h96);
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    q       = prdata;
    slv_q   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    int n, k, c0, c1;
    logic [31:0] q;
    {presetn, psel, penable, pwrite, trip, rkey, rdin, start, slow} = '0;
    {paddr, pwdata, loop_sel, fout, ftheo} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(`OFS_RETRY_CFG, 32'h000A0000);
    rdchk(`OFS_SLEEP_CFG, 32'h00648000);
    rdchk(`OFS_SLEEP_THR, 32'h01F40000);
    rdchk(8'h20, 32'h0);
    chk({31'h0, slv_q}, 32'h1);
    wr(`OFS_RETRY_CFG, 32'h0FFF000A);
    rdchk(`OFS_RETRY_CFG, 32'h07080000);
    wr(`OFS_SLEEP_CFG, 32'h00FF01FF);
    rdchk(`OFS_SLEEP_CFG, 32'h00C8012C);
    $display("test registers done");
    // Manual recovery and interrupt
    wr(`OFS_RETRY_CFG, 32'h0);
    c0 = n_fault;
    trip <= 1'b1;
    repeat (40) @(posedge pclk);
    chk(32'(n_fault - c0), 32'h0);
    apb(1'b0, `OFS_STATUS, 32'h0, q);
    chk({30'h0, q[3:2]}, 32'h2);
    chk({31'h0, irq}, 32'h0);
    wr(`OFS_IRQ_MASK, 32'h1);
    chk({31'h0, irq}, 32'h1);
    trip <= 1'b0;
    repeat (6) @(posedge pclk);
    rkey <= 1'b1;
    repeat (6) @(posedge pclk);
    rkey <= 1'b0;
    repeat (6) @(posedge pclk);
    chk(32'(n_fault - c0), 32'h1);
    wr(`OFS_IRQ_STAT, 32'h1F);
    chk({31'h0, irq}, 32'h0);
    $display("test manual done");
    // Every automatic code, delay 0; the last one is unlimited
    for (k = 0; k < 9; k++)
    begin
      wr(`OFS_RETRY_CFG, 32'(k + 1));
      wr(`OFS_COMMAND, 32'h1);
      c0 = n_restart;
      trip <= 1'b1;
      for (n = 0; n < 600 && n_restart - c0 < TRIES[k] + (k < 8 ? 1 : 0); n++)
        @(posedge pclk);
      chk(32'(n_restart - c0), 32'(TRIES[k]));
      apb(1'b0, `OFS_STATUS, 32'h0, q);
      chk(32'(q[3:2] == 2'h2), 32'(k < 8));
      trip <= 1'b0;
      repeat (6) @(posedge pclk);
      rdin <= 1'b1;
      repeat (6) @(posedge pclk);
      rdin <= 1'b0;
      repeat (6) @(posedge pclk);
    end
    $display("test attempts done");
    wr(`OFS_RETRY_CFG, 32'h00020001);
    wr(`OFS_COMMAND, 32'h1);
    c0 = n_restart;
    trip <= 1'b1;
    for (n = 0; n < 200 && n_restart == c0; n++)
      @(posedge pclk);
    chk(32'(n >= 20 && n <= 40), 32'h1);
    trip <= 1'b0;
    repeat (6) @(posedge pclk);
    wr(`OFS_COMMAND, 32'h1);
    $display("test delay done");
    // Catch codes, mode 1 above f_max, brake mode with braking disabled
    for (k = 0; k < 6; k++)
    begin
      wr(`OFS_CATCH_CFG, 32'(k < 4 ? k : k - 3));
      fout <= (k == 4) ? 16'h0300 : 16'h0100;
      slow <= (k == 5);
      c0 = n_catch;
      c1 = n_restart;
      n = n_brake;
      start <= 1'b1;
      repeat (60) @(posedge pclk);
      start <= 1'b0;
      repeat (10) @(posedge pclk);
      chk(32'(n_catch - c0), 32'(k != 0 && k < 4));
      chk(32'(n_restart - c1), 32'(k == 2 || k == 3));
      chk(32'(n_brake > n), 32'(k == 2 || k == 3));
    end
    $display("test catch done");
    // Sleep with catch off: local and jog inhibit, timer clearing, wake threshold, boost time-out
    wr(`OFS_CATCH_CFG, 32'h0);
    wr(`OFS_SLEEP_THR, 32'h012C0064);
    wr(`OFS_SLEEP_CFG, 32'h00960002);
    fout <= 16'h0032;
    for (k = 0; k < 2; k++)
    begin
      loop_sel <= k ? 3'b001 : 3'b010;
      repeat (100) @(posedge pclk);
      chk({31'h0, drive_out.sleeping}, 32'h0);
    end
    loop_sel <= 3'b000;
    c0 = n_boost;
    repeat (6)
    begin
      fout <= 16'h0032;
      repeat (9) @(posedge pclk);
      fout <= 16'h0070;
      repeat (3) @(posedge pclk);
    end
    chk({31'h0, drive_out.ramp_down}, 32'h0);
    fout <= 16'h0032;
    for (n = 0; n < 200 && drive_out.sleeping !== 1'b1; n++)
      @(posedge pclk);
    chk({31'h0, drive_out.sleeping}, 32'h1);
    chk(32'(n_boost - c0), 32'h0);
    rdchk(`OFS_IRQ_STAT, 32'h0F);
    ftheo <= 16'h012C;
    repeat (20) @(posedge pclk);
    chk({31'h0, drive_out.sleeping}, 32'h1);
    c1 = n_restart;
    ftheo <= 16'h012D;
    for (n = 0; n < 50 && drive_out.sleeping !== 1'b0; n++)
      @(posedge pclk);
    ftheo <= 16'h0000;
    repeat (4) @(posedge pclk);
    chk(32'(n_restart - c1), 32'h1);
    loop_sel <= 3'b100;
    slow <= 1'b1;
    c0 = n_boost;
    for (n = 0; n < 800 && drive_out.sleeping !== 1'b0; n++)
      @(posedge pclk);
    for (n = 0; n < 800 && drive_out.sleeping !== 1'b1; n++)
      @(posedge pclk);
    chk({31'h0, drive_out.sleeping}, 32'h1);
    chk(32'(n_boost - c0 >= 300 && n_boost - c0 <= 320), 32'h1);
    chk(32'(n_bad), 32'h0);
    $display("test sleep done");
    results;
  end

  // Watchdog well beyond the expected run
  initial
  begin
    #200000;
    err_total++;
    $display("watchdog expired");
    results;
  end
endmodule
